/* File: hdl/gpb_defs.vh */
// gpb_defs.vh: register map, reset values and layout constants for the gpio port block
// assumes: included by bare name from every design file of the block
`ifndef GPB_DEFS_VH
`define GPB_DEFS_VH

// register byte offsets within one port instance
`define GPB_OFS_PIN_INPUT_LEVEL   12'h000
`define GPB_OFS_PIN_OUTPUT_LEVEL  12'h004
`define GPB_OFS_PIN_DIRECTION     12'h008

// reset values
`define GPB_RST_PIN_OUTPUT_LEVEL  32'h00000000
`define GPB_RST_PIN_DIRECTION     32'h00000000

// instance address map
`define GPB_NUM_PORTS             6
`define GPB_PORT_STRIDE           32'h00001000
`define GPB_BASE_ADDR             32'hE004A000
`define GPB_PORT_SEL_LSB          12
`define GPB_REG_ADDR_MSB          11

// bus and port widths
`define GPB_DATA_W                32
`define GPB_ADDR_W                32
`define GPB_PORT_W                32

// axi response codes
`define GPB_RESP_OKAY             2'h0
`define GPB_RESP_SLVERR           2'h2

// synchroniser depth
`define GPB_SYNC_STAGES           2

`endif

/* File: hdl/gpb_sync.v */
// gpb_sync.v: multi-stage synchroniser for a vector of pin inputs
// assumes: inputs are asynchronous to i_clk; only the last stage is read outside
`timescale 1ns/10ps
`include "gpb_defs.vh"

module gpb_sync #(
    parameter WIDTH  = 32,
    parameter STAGES = `GPB_SYNC_STAGES
)
(
    // clock and reset
    input  wire             i_clk,
    input  wire             i_rst,
    // data
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] stage_q [0:STAGES-1];
    integer         k;

    // chain of flops; first stage feeds only the second
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (k = 0; k < STAGES; k = k + 1)
                stage_q[k] <= {WIDTH{1'b0}};
        end
        else
        begin
            stage_q[0] <= i_async;
            for (k = 1; k < STAGES; k = k + 1)
                stage_q[k] <= stage_q[k-1];
        end
    end

    assign o_sync = stage_q[STAGES-1];

endmodule // gpb_sync

/* File: hdl/gpb_port.v */
// gpb_port.v: one gpio port: pin sync, output level and direction registers
// assumes: register access strobes come from a bus slave on the same clock
`timescale 1ns/10ps
`include "gpb_defs.vh"

module gpb_port #(
    parameter [31:0] PIN_MASK = 32'hFFFFFFFF
)
(
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // register access
    input  wire        i_wr_out,
    input  wire        i_wr_dir,
    input  wire [31:0] i_wdata,
    output wire [31:0] o_in_level,
    output wire [31:0] o_out_level,
    output wire [31:0] o_dir,
    // pins
    input  wire [31:0] i_pin,
    input  wire [31:0] i_routed,
    output wire [31:0] o_pin_out,
    output wire [31:0] o_pin_oe
);

    reg  [31:0] out_q;
    reg  [31:0] dir_q;
    wire [31:0] sync_pin;

    // pins pass the synchroniser before any logic reads them
    gpb_sync #(
        .WIDTH  (32),
        .STAGES (`GPB_SYNC_STAGES)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_pin),
        .o_sync  (sync_pin)
    );

    // absent pins hold zero
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            out_q <= `GPB_RST_PIN_OUTPUT_LEVEL;
            dir_q <= `GPB_RST_PIN_DIRECTION;
        end
        else
        begin
            if (i_wr_out)
                out_q <= i_wdata & PIN_MASK;
            if (i_wr_dir)
                dir_q <= i_wdata & PIN_MASK;
        end
    end

    assign o_in_level  = sync_pin & i_routed & PIN_MASK;
    assign o_out_level = out_q;
    assign o_dir       = dir_q;
    assign o_pin_out   = out_q & i_routed;
    assign o_pin_oe    = dir_q & i_routed;

endmodule // gpb_port

/* File: hdl/gpb_top.v */
// gpb_top.v: six gpio ports behind one axi4-lite slave
// assumes: pins arrive asynchronously; a pad routing unit supplies per-pin route flags
`timescale 1ns/10ps
`include "gpb_defs.vh"

// Overview of operation
// - each port has up to 32 pins, each with its own direction and output level bit.
// - reading the input-level register returns each pin level after synchronisation.
// - writing the input-level register stores the value into the output-level register.
// - bits of unimplemented pins are reserved and always read as zero.
// - an input that is not routed to a pad reads as a constant zero.
// - an output that is not routed to a pad drives nothing.
// - an input-level bit reads one for a high pin and zero for a low pin.
// - six identical ports sit at bases spaced 0x1000 apart.
// - the set of implemented pins is configurable for each port.
// - an output-level bit drives a pin high when one and low when zero, resetting to zero.
// - a direction bit of one enables the driver, zero makes an input, resetting to zero.
module gpb_top #(
    parameter [31:0]  BASE_ADDR   = `GPB_BASE_ADDR,
    parameter [191:0] PIN_MASKS   = {32'h000FFFFF, 32'h00FFFFFF, 32'h0000FFFF,
                                     32'h0FFFFFFF, 32'h0FFFFFFF, 32'hFFFFFFFF}
)
(
    // clock and reset
    input  wire         I_REF_CLK,
    input  wire         I_RST,
    // axi4-lite write address
    input  wire         I_AWVALID,
    output reg          O_AWREADY,
    input  wire [31:0]  I_AWADDR,
    input  wire [2:0]   I_AWPROT,
    // axi4-lite write data
    input  wire         I_WVALID,
    output reg          O_WREADY,
    input  wire [31:0]  I_WDATA,
    input  wire [3:0]   I_WSTRB,
    // axi4-lite write response
    output reg          O_BVALID,
    input  wire         I_BREADY,
    output reg  [1:0]   O_BRESP,
    // axi4-lite read address
    input  wire         I_ARVALID,
    output reg          O_ARREADY,
    input  wire [31:0]  I_ARADDR,
    input  wire [2:0]   I_ARPROT,
    // axi4-lite read data
    output reg          O_RVALID,
    input  wire         I_RREADY,
    output reg  [31:0]  O_RDATA,
    output reg  [1:0]   O_RRESP,
    // pins, port n in bits 32n+31..32n
    input  wire [191:0] I_PIN,
    input  wire [191:0] I_PIN_ROUTED,
    output reg  [191:0] O_PIN,
    output reg  [191:0] O_PIN_OE
);

    localparam NP = `GPB_NUM_PORTS;

    // decode results
    reg         aw_hold_q;
    reg  [31:0] aw_addr_q;
    reg         w_hold_q;
    reg  [31:0] w_data_q;
    wire        do_write;
    wire        do_read;
    reg  [2:0]  wr_port;
    reg  [1:0]  wr_reg;
    reg         wr_ok;
    reg  [2:0]  rd_port;
    reg  [1:0]  rd_reg;
    reg         rd_ok;
    reg  [31:0] rd_val;

    // per-port buses
    wire [NP-1:0] wr_out;
    wire [NP-1:0] wr_dir;
    wire [191:0]  in_lv;
    wire [191:0]  out_lv;
    wire [191:0]  dir_lv;
    wire [191:0]  pin_o;
    wire [191:0]  pin_oe;

    // decode an address into port, register and hit flag
    function [5:0] gpb_decode;
        input [31:0] addr;
        reg   [31:0] rel;
        reg   [31:0] idx;
        reg   [11:0] ofs;
        reg   [1:0]  r;
        reg          hit;
        begin
            rel = addr - BASE_ADDR;
            idx = rel >> `GPB_PORT_SEL_LSB;
            ofs = rel[`GPB_REG_ADDR_MSB:0];
            r   = 2'h3;
            hit = 1'b0;
            if (addr >= BASE_ADDR && idx < NP)
            begin
                case (ofs)
                    `GPB_OFS_PIN_INPUT_LEVEL:  r = 2'h0;
                    `GPB_OFS_PIN_OUTPUT_LEVEL: r = 2'h1;
                    `GPB_OFS_PIN_DIRECTION:    r = 2'h2;
                    default:                   r = 2'h3;
                endcase
                hit = (r != 2'h3);
            end
            gpb_decode = {hit, idx[2:0], r};
        end
    endfunction

    assign do_write = aw_hold_q && w_hold_q && !O_BVALID;
    assign do_read  = I_ARVALID && O_ARREADY;

    always @*
    begin
        {wr_ok, wr_port, wr_reg} = gpb_decode(aw_addr_q);
        {rd_ok, rd_port, rd_reg} = gpb_decode(I_ARADDR);
    end

    // address and data may arrive in either order
    always @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 32'h00000000;
            w_hold_q  <= 1'b0;
            w_data_q  <= 32'h00000000;
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            O_BVALID  <= 1'b0;
            O_BRESP   <= `GPB_RESP_OKAY;
        end
        else
        begin
            O_AWREADY <= !aw_hold_q && !(I_AWVALID && O_AWREADY);
            O_WREADY  <= !w_hold_q && !(I_WVALID && O_WREADY);
            if (I_AWVALID && O_AWREADY)
            begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= I_AWADDR;
            end
            if (I_WVALID && O_WREADY)
            begin
                w_hold_q <= 1'b1;
                w_data_q <= I_WDATA;
            end
            if (do_write)
            begin
                O_BVALID  <= 1'b1;
                O_BRESP   <= wr_ok ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
            end
            else if (O_BVALID && I_BREADY)
                O_BVALID <= 1'b0;
        end
    end

    // write strobes per port; input-level writes land in output level
    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1)
        begin : g_port
            assign wr_out[g] = do_write && wr_ok && wr_port == g &&
                               (wr_reg == 2'h0 || wr_reg == 2'h1);
            assign wr_dir[g] = do_write && wr_ok && wr_port == g && wr_reg == 2'h2;

            gpb_port #(
                .PIN_MASK (PIN_MASKS[32*g +: 32])
            ) u_port (
                .i_clk       (I_REF_CLK),
                .i_rst       (I_RST),
                .i_wr_out    (wr_out[g]),
                .i_wr_dir    (wr_dir[g]),
                .i_wdata     (w_data_q),
                .o_in_level  (in_lv[32*g +: 32]),
                .o_out_level (out_lv[32*g +: 32]),
                .o_dir       (dir_lv[32*g +: 32]),
                .i_pin       (I_PIN[32*g +: 32]),
                .i_routed    (I_PIN_ROUTED[32*g +: 32]),
                .o_pin_out   (pin_o[32*g +: 32]),
                .o_pin_oe    (pin_oe[32*g +: 32])
            );
        end
    endgenerate

    // read mux; reserved bits already masked to zero
    always @*
    begin
        case (rd_reg)
            2'h0:    rd_val = in_lv[32*rd_port +: 32];
            2'h1:    rd_val = out_lv[32*rd_port +: 32];
            2'h2:    rd_val = dir_lv[32*rd_port +: 32];
            default: rd_val = 32'h00000000;
        endcase
    end

    // single outstanding read
    always @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h00000000;
            O_RRESP   <= `GPB_RESP_OKAY;
        end
        else
        begin
            O_ARREADY <= !O_RVALID && !do_read;
            if (do_read)
            begin
                O_RVALID <= 1'b1;
                O_RDATA  <= rd_ok ? rd_val : 32'h00000000;
                O_RRESP  <= rd_ok ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
            end
            else if (O_RVALID && I_RREADY)
                O_RVALID <= 1'b0;
        end
    end

    // pin drivers registered; unrouted outputs go nowhere
    always @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_PIN    <= {192{1'b0}};
            O_PIN_OE <= {192{1'b0}};
        end
        else
        begin
            O_PIN    <= pin_o;
            O_PIN_OE <= pin_oe;
        end
    end

endmodule // gpb_top

/* File: verification/gpb_top_props.sv */
// gpb_top_props.sv: port assertions for the gpio port block
// assumes: bound to gpb_top, one clock, reset active high
`timescale 1ns/10ps
module gpb_top_props #(
    parameter [191:0] PIN_MASKS = {6{32'hFFFFFFFF}}
)
(
    input wire         I_REF_CLK,
    input wire         I_RST,
    input wire         I_AWVALID,
    input wire         O_AWREADY,
    input wire         I_WVALID,
    input wire         O_WREADY,
    input wire         O_BVALID,
    input wire         I_BREADY,
    input wire [1:0]   O_BRESP,
    input wire         I_ARVALID,
    input wire         O_ARREADY,
    input wire         O_RVALID,
    input wire         I_RREADY,
    input wire [31:0]  O_RDATA,
    input wire [191:0] I_PIN_ROUTED,
    input wire [191:0] O_PIN,
    input wire [191:0] O_PIN_OE
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    a_out_routed: assert property ((O_PIN & ~$past(I_PIN_ROUTED)) == 0)
        else $error("level on unrouted pin");
    a_oe_routed: assert property ((O_PIN_OE & ~$past(I_PIN_ROUTED)) == 0)
        else $error("driver on unrouted pin");
    a_pin_masked: assert property (((O_PIN | O_PIN_OE) & ~PIN_MASKS) == 0)
        else $error("absent pin driven");
    a_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped");
    a_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped");
    a_wr_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:3] O_BVALID)
        else $error("no write response");
    a_rd_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("no read response");
    a_aw_drop: assert property (I_AWVALID && O_AWREADY |=> !O_AWREADY)
        else $error("address ready held");
    a_oe_after_wr: assert property ($changed(O_PIN_OE) &&
        ($past(I_PIN_ROUTED) == $past(I_PIN_ROUTED, 2)) |-> $past(O_BVALID))
        else $error("driver changed without write");
    c_write: cover property (O_BVALID && I_BREADY && O_BRESP == 2'h0);
    c_slverr: cover property (O_BVALID && O_BRESP == 2'h2);
    c_drive: cover property (O_PIN_OE != 0);
    c_r_wait: cover property (O_RVALID && !I_RREADY);
endmodule // gpb_top_props

bind gpb_top gpb_top_props #(.PIN_MASKS(PIN_MASKS)) i_props (.I_REF_CLK, .I_RST, .I_AWVALID, .O_AWREADY,
    .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY,
    .O_RDATA, .I_PIN_ROUTED, .O_PIN, .O_PIN_OE);

/* File: verification/gpb_pad_model.sv */
// gpb_pad_model.sv: pads beyond the routing unit
// assumes: i_ext is the outside world, pull-ups included
`timescale 1ns/10ps
module gpb_pad_model (
    input  wire [191:0] i_out,
    input  wire [191:0] i_oe,
    input  wire [191:0] i_ext,
    output wire [191:0] o_line
);
    // driven pads show the port level, released ones the outside
    assign o_line = (i_oe & i_out) | (~i_oe & i_ext);
endmodule // gpb_pad_model

/* File: verification/tb_gpio_port_block.sv */
// tb_gpio_port_block.sv: self-checking bench for gpb_top
// assumes: default pin masks, pad model on the pins
`timescale 1ns/10ps
module tb_gpio_port_block;
    localparam [191:0] MASKS = {32'h000FFFFF, 32'h00FFFFFF, 32'h0000FFFF,
                                32'h0FFFFFFF, 32'h0FFFFFFF, 32'hFFFFFFFF};
    logic         I_REF_CLK = 0, I_RST = 1;
    logic         I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0, I_ARVALID = 0, I_RREADY = 0;
    logic [31:0]  I_AWADDR = 0, I_WDATA = 0, I_ARADDR = 0, out_m[6], dir_m[6], m, r, x;
    logic [191:0] I_PIN_ROUTED = 0, ext = 0;
    wire          O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    wire [1:0]    O_BRESP, O_RRESP;
    wire [31:0]   O_RDATA;
    wire [191:0]  I_PIN, O_PIN, O_PIN_OE;
    logic [33:0]  rq[$], bq[$];
    int           miscompares = 0, n_compared = 0, seed = 32'h7059f986, k, p;

    always #4 I_REF_CLK = ~I_REF_CLK;

    gpb_top i_dut (.I_REF_CLK, .I_RST, .I_AWVALID, .O_AWREADY, .I_AWADDR, .I_AWPROT(3'h0), .I_WVALID,
        .O_WREADY, .I_WDATA, .I_WSTRB(4'hF), .O_BVALID, .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY,
        .I_ARADDR, .I_ARPROT(3'h0), .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP, .I_PIN, .I_PIN_ROUTED,
        .O_PIN, .O_PIN_OE);
    gpb_pad_model i_pads (.i_out(O_PIN), .i_oe(O_PIN_OE), .i_ext(ext), .o_line(I_PIN));

    function automatic [31:0] ad(input int pt, input int o);
        return 32'hE004A000 + 32'h00001000 * pt + o;
    endfunction

    task automatic cmp(input [33:0] got, input [33:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // write with both channels offered together; response ready after a random lag
    task automatic wr(input [31:0] a, input [31:0] d, input [1:0] rs);
        bit aw = 0, w = 0;
        int lag;
        lag = $random(seed) & 3;
        @(posedge I_REF_CLK);
        bq.push_back({32'h0, rs});
        I_AWVALID <= 1;
        I_AWADDR  <= a;
        I_WVALID  <= 1;
        I_WDATA   <= d;
        I_BREADY  <= (lag == 0);
        while (!(aw && w))
        begin
            @(posedge I_REF_CLK);
            if (I_AWVALID && O_AWREADY)
            begin
                aw = 1;
                I_AWVALID <= 0;
            end
            if (I_WVALID && O_WREADY)
            begin
                w = 1;
                I_WVALID <= 0;
            end
        end
        do @(posedge I_REF_CLK); while (!O_BVALID);
        if (lag != 0)
        begin
            repeat (lag - 1) @(posedge I_REF_CLK);
            I_BREADY <= 1;
            @(posedge I_REF_CLK);
        end
        I_BREADY <= 0;
    endtask

    // read; data ready after a random lag
    task automatic rd(input [31:0] a, input [33:0] e);
        int lag;
        lag = $random(seed) & 3;
        @(posedge I_REF_CLK);
        rq.push_back(e);
        I_ARVALID <= 1;
        I_ARADDR  <= a;
        I_RREADY  <= (lag == 0);
        do @(posedge I_REF_CLK); while (!O_ARREADY);
        I_ARVALID <= 0;
        do @(posedge I_REF_CLK); while (!O_RVALID);
        if (lag != 0)
        begin
            repeat (lag - 1) @(posedge I_REF_CLK);
            I_RREADY <= 1;
            @(posedge I_REF_CLK);
        end
        I_RREADY <= 0;
    endtask

    // result watcher
    always @(posedge I_REF_CLK)
    begin
        if (O_RVALID && I_RREADY)
            cmp({O_RRESP, O_RDATA}, rq.pop_front());
        if (O_BVALID && I_BREADY)
            cmp({32'h0, O_BRESP}, bq.pop_front());
    end

    initial
    begin
        repeat (20000) @(posedge I_REF_CLK);
        miscompares++;
        report_and_stop;
    end

    initial
    begin
        repeat (20) @(posedge I_REF_CLK);
        I_RST <= 0;
        for (p = 0; p < 6; p++)
        begin
            rd(ad(p, 4), 34'h0);
            rd(ad(p, 8), 34'h0);
        end
        rd(ad(2, 12), {2'h2, 32'h0});
        wr(ad(5, 12), 32'hFFFFFFFF, 2'h2);
        for (k = 0; k < 4; k++)
        begin
            for (p = 0; p < 6; p++)
            begin
                I_PIN_ROUTED[32*p +: 32] <= $random(seed);
                ext[32*p +: 32] <= $random(seed);
                out_m[p] = (k == 0) ? 32'h0 : $random(seed);
                dir_m[p] = $random(seed);
                wr(ad(p, (k & 1) * 4), out_m[p], 2'h0);
                wr(ad(p, 8), dir_m[p], 2'h0);
            end
            repeat (6) @(posedge I_REF_CLK);
            for (p = 0; p < 6; p++)
            begin
                m = MASKS[32*p +: 32];
                r = I_PIN_ROUTED[32*p +: 32];
                x = ((dir_m[p] & out_m[p]) | (~dir_m[p] & ext[32*p +: 32])) & r & m;
                rd(ad(p, 4), {2'h0, out_m[p] & m});
                rd(ad(p, 8), {2'h0, dir_m[p] & m});
                rd(ad(p, 0), {2'h0, x});
                cmp({2'h0, O_PIN[32*p +: 32]}, {2'h0, out_m[p] & r & m});
                cmp({2'h0, O_PIN_OE[32*p +: 32]}, {2'h0, dir_m[p] & r & m});
            end
        end
        @(posedge I_REF_CLK);
        I_RST <= 1;
        repeat (2) @(posedge I_REF_CLK);
        I_RST <= 0;
        for (p = 0; p < 6; p++)
        begin
            rd(ad(p, 8), 34'h0);
            rd(ad(p, 4), 34'h0);
            cmp({2'h0, O_PIN_OE[32*p +: 32]}, 34'h0);
        end
        report_and_stop;
    end
endmodule // tb_gpio_port_block
